// ### core_model.sv
`timescale 1ns/1ps
// ======
// Core stand-in: loopback, config and stats answers
module core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic corrupt_i,
  input wire logic bad_stats_i,
  input wire logic tx_valid_i,
  input wire logic [31:0] tx_data_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [31:0] rx_data_o,
  output logic rx_sop_o,
  output logic rx_eop_o,
  input wire logic cfg_en_i,
  output logic cfg_rdy_o,
  input wire logic stat_arvalid_i,
  input wire logic [31:0] stat_araddr_i,
  output logic stat_arready_o,
  output logic stat_rvalid_o,
  output logic [31:0] stat_rdata_o,
  input wire logic stat_rready_i
);
  logic [2:0] cfg_dly_ff; // Config write latency
  wire beat = tx_valid_i && tx_ready_o; // Beat accepted
  assign tx_ready_o = !stall_i;
  assign cfg_rdy_o = cfg_dly_ff[2];
  // Loopback one cycle late; idle data toggles
  always_ff @(posedge clk_i) begin
    rx_valid_o <= beat;
    rx_sop_o <= beat && tx_sop_i;
    rx_eop_o <= beat && tx_eop_i;
    rx_data_o <= rst_i ? 32'h0000_0000 : beat ? tx_data_i ^ {31'h0, corrupt_i} : ~rx_data_o;
    cfg_dly_ff <= rst_i ? 3'h0 : {cfg_dly_ff[1:0], cfg_en_i};
    stat_arready_o <= !rst_i && stat_arvalid_i && !stat_arready_o;
    stat_rvalid_o <= !rst_i && ((stat_arvalid_i && stat_arready_o)
      || (stat_rvalid_o && !stat_rready_i));
    // RX counter can be skewed
    if (stat_arvalid_i && stat_arready_o) begin
      stat_rdata_o <= 32'h0000_0100
        + {31'h0, bad_stats_i && stat_araddr_i == tester_pkg::STAT_RX_ADDR};
    end else if (!stat_rvalid_o) begin
      stat_rdata_o <= rst_i ? 32'h0000_0000 : ~stat_rdata_o;
    end
  end
endmodule

// ### eth_traffic_sanity_tester.sv
`timescale 1ns/1ps
module eth_traffic_sanity_tester (
  input wire logic clk_i,
  input wire logic rst_i,
  // Board pins and core status
  input wire logic continuous_traffic_select_i,
  input wire logic lane_mode_change_pulse_i,
  input wire logic test_restart_request_i,
  input wire logic perf_snapshot_pulse_i,
  input wire logic rx_transceiver_locked_i,
  input wire logic tx_transceiver_locked_i,
  input wire logic rx_aligned_i,
  input wire logic remote_receiver_aligned_i,
  // Transmit stream to the core
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [31:0] tx_data_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  // Receive stream from the core
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_data_i,
  input wire logic rx_sop_i,
  input wire logic rx_eop_i,
  // Transceiver configuration port
  output logic cfg_en_o,
  output logic cfg_we_o,
  output logic [9:0] cfg_addr_o,
  output logic [15:0] cfg_wdata_o,
  input wire logic cfg_rdy_i,
  output logic reconfig_write_complete_o,
  // Statistics read channel
  output logic [31:0] stat_araddr_o,
  output logic stat_arvalid_o,
  input wire logic stat_arready_i,
  input wire logic [31:0] stat_rdata_i,
  input wire logic stat_rvalid_i,
  output logic stat_rready_o,
  // Indicators
  output logic tx_transceiver_lock_indicator_o,
  output logic rx_transceiver_lock_indicator_o,
  output logic rx_alignment_indicator_o,
  output logic gen_busy_indicator_o,
  output logic mon_busy_indicator_o,
  output logic gen_complete_indicator_o,
  output logic mon_complete_indicator_o,
  output logic mon_mismatch_indicator_o,
  output logic lane_mode_indicator_o,
  output logic stats_match_indicator_o,
  // Wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o
);

  // ==========================================================
  // Pin synchronisation
  logic [tester_pkg::PIN_W-1:0] pins; // Raw pin vector
  logic [tester_pkg::PIN_W-1:0] lvl; // Synchronised levels
  logic [tester_pkg::PIN_W-1:0] rise; // Rising edge pulses

  assign pins = {remote_receiver_aligned_i, rx_aligned_i, tx_transceiver_locked_i,
                 rx_transceiver_locked_i, perf_snapshot_pulse_i, test_restart_request_i,
                 lane_mode_change_pulse_i, continuous_traffic_select_i};

  input_sync #(.W(tester_pkg::PIN_W)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins),
    .level_o(lvl),
    .rise_o(rise)
  );

  wire continuous = lvl[tester_pkg::PIN_CONT];
  wire rx_lock = lvl[tester_pkg::PIN_RX_LOCK];
  wire tx_lock = lvl[tester_pkg::PIN_TX_LOCK];
  wire aligned = lvl[tester_pkg::PIN_ALIGN];
  wire remote_ok = lvl[tester_pkg::PIN_REMOTE];

  // ==========================================================
  // State and counters
  tester_pkg::run_state_t gen_ff; // Generator state
  tester_pkg::run_state_t mon_ff; // Monitor state
  logic [15:0] gen_pkt_ff; // Packets sent
  logic [7:0] gen_beat_ff; // Beat within packet
  logic [15:0] mon_pkt_ff; // Packets received
  logic [7:0] mon_beat_ff; // Expected beat
  logic mismatch_ff; // Sticky compare failure
  logic [15:0] target_ff; // Fixed-run packet count
  logic lane_mode_ff; // High for CAUI-4
  logic cfg_busy; // Config writes in progress
  logic cfg_done; // Config writes finished

  wire gen_busy = (gen_ff == tester_pkg::RUN_WAIT) | (gen_ff == tester_pkg::RUN_ACTIVE);
  wire mon_busy = (mon_ff == tester_pkg::RUN_WAIT) | (mon_ff == tester_pkg::RUN_ACTIVE);
  wire restart_ok = rise[tester_pkg::PIN_RESTART] & ~gen_busy & ~mon_busy;
  wire start_run = restart_ok | cfg_done;
  wire lane_req = rise[tester_pkg::PIN_LANE] & ~cfg_busy & tester_pkg::RUNTIME_SWITCH_BUILD;
  wire link_ok = rx_lock & aligned & ~cfg_busy;
  // Simplex transmit needs transmit lock and the far receiver aligned instead of the local receive link
  wire gen_go = tester_pkg::SIMPLEX_TX_BUILD ? (tx_lock & remote_ok & ~cfg_busy)
                                             : link_ok;
  wire tx_fire = tx_valid_o & tx_ready_i;
  wire tx_last = (gen_beat_ff == tester_pkg::PKT_LAST_BEAT);
  wire gen_end = tx_fire & tx_last & ~continuous & (gen_pkt_ff + 16'h0001 == target_ff);
  wire rx_take = rx_valid_i & (mon_ff == tester_pkg::RUN_ACTIVE);
  wire [31:0] rx_expect = {mon_pkt_ff, tester_pkg::PAD_BYTE, mon_beat_ff};
  wire rx_bad = rx_take & ((rx_data_i != rx_expect) | (rx_sop_i != (mon_beat_ff == 8'h00))
                | (rx_eop_i != (mon_beat_ff == tester_pkg::PKT_LAST_BEAT)));
  wire mon_end = rx_take & rx_eop_i & ~continuous & (mon_pkt_ff + 16'h0001 == target_ff);

  // ==========================================================
  // Packet generator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_ff <= tester_pkg::RUN_WAIT;
      gen_pkt_ff <= '0;
      gen_beat_ff <= '0;
    end else if (start_run | lane_req) begin
      // Fresh run, or park while lanes change
      gen_ff <= tester_pkg::RUN_WAIT;
      gen_pkt_ff <= '0;
      gen_beat_ff <= '0;
    end else begin
      case (gen_ff)
        tester_pkg::RUN_WAIT: if (gen_go) gen_ff <= tester_pkg::RUN_ACTIVE;
        tester_pkg::RUN_ACTIVE: begin
          if (tx_fire) begin
            gen_beat_ff <= tx_last ? 8'h00 : gen_beat_ff + 8'h01;
            if (tx_last) gen_pkt_ff <= gen_pkt_ff + 16'h0001;
          end
          if (gen_end) gen_ff <= tester_pkg::RUN_DONE;
        end
        tester_pkg::RUN_DONE: gen_ff <= tester_pkg::RUN_DONE;
        default: gen_ff <= tester_pkg::RUN_IDLE;
      endcase
    end
  end

  assign tx_valid_o = (gen_ff == tester_pkg::RUN_ACTIVE);
  assign tx_data_o = {gen_pkt_ff, tester_pkg::PAD_BYTE, gen_beat_ff};
  assign tx_sop_o = tx_valid_o & (gen_beat_ff == 8'h00);
  assign tx_eop_o = tx_valid_o & tx_last;

  // ==========================================================
  // Packet monitor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_ff <= tester_pkg::RUN_WAIT;
      mon_pkt_ff <= '0;
      mon_beat_ff <= '0;
      mismatch_ff <= 1'b0;
    end else if (start_run | lane_req) begin
      mon_ff <= tester_pkg::RUN_WAIT;
      mon_pkt_ff <= '0;
      mon_beat_ff <= '0;
      mismatch_ff <= 1'b0;
    end else begin
      if (rx_bad) mismatch_ff <= 1'b1;
      case (mon_ff)
        tester_pkg::RUN_WAIT: if (link_ok) mon_ff <= tester_pkg::RUN_ACTIVE;
        tester_pkg::RUN_ACTIVE: begin
          if (rx_take) begin
            mon_beat_ff <= rx_eop_i ? 8'h00 : mon_beat_ff + 8'h01;
            if (rx_eop_i) mon_pkt_ff <= mon_pkt_ff + 16'h0001;
          end
          if (mon_end) mon_ff <= tester_pkg::RUN_DONE;
        end
        tester_pkg::RUN_DONE: mon_ff <= tester_pkg::RUN_DONE;
        default: mon_ff <= tester_pkg::RUN_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Lane mode reconfiguration
  reconfig_writer u_cfg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(lane_req),
    .target_caui4_i(~lane_mode_ff),
    .cfg_en_o(cfg_en_o),
    .cfg_we_o(cfg_we_o),
    .cfg_addr_o(cfg_addr_o),
    .cfg_wdata_o(cfg_wdata_o),
    .cfg_rdy_i(cfg_rdy_i),
    .busy_o(cfg_busy),
    .done_o(cfg_done)
  );

  // Lane mode flips once the writes are through
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_mode_ff <= tester_pkg::LANE_MODE_RST;
    end else if (cfg_done) begin
      lane_mode_ff <= ~lane_mode_ff;
    end
  end

  assign reconfig_write_complete_o = cfg_done;

  // ==========================================================
  // Statistics snapshot and compare
  tester_pkg::stat_state_t st_ff; // Read sequencer
  tester_pkg::stat_state_t nxt_st;
  logic [31:0] araddr_ff; // Held read address
  logic [31:0] tx_stat_ff; // Captured transmit counter
  logic match_ff; // Compare result

  wire snap = rise[tester_pkg::PIN_SNAP] & tester_pkg::STATS_BUILD;
  wire ar_phase = (st_ff == tester_pkg::ST_AR_TX) | (st_ff == tester_pkg::ST_AR_RX);
  wire r_phase = (st_ff == tester_pkg::ST_R_TX) | (st_ff == tester_pkg::ST_R_RX);

  // Read transmit counter, then receive counter
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      tester_pkg::ST_IDLE: if (snap) nxt_st = tester_pkg::ST_AR_TX;
      tester_pkg::ST_AR_TX: if (stat_arready_i) nxt_st = tester_pkg::ST_R_TX;
      tester_pkg::ST_R_TX: if (stat_rvalid_i) nxt_st = tester_pkg::ST_AR_RX;
      tester_pkg::ST_AR_RX: if (stat_arready_i) nxt_st = tester_pkg::ST_R_RX;
      tester_pkg::ST_R_RX: if (stat_rvalid_i) nxt_st = tester_pkg::ST_IDLE;
      default: nxt_st = tester_pkg::ST_IDLE;
    endcase
  end

  // Address, capture and compare registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= tester_pkg::ST_IDLE;
      araddr_ff <= '0;
      tx_stat_ff <= '0;
      match_ff <= tester_pkg::STATS_MATCH_RST;
    end else begin
      st_ff <= nxt_st;
      araddr_ff <= (nxt_st == tester_pkg::ST_AR_RX) ? tester_pkg::STAT_RX_ADDR
                                                  : tester_pkg::STAT_TX_ADDR;
      if (st_ff == tester_pkg::ST_R_TX && stat_rvalid_i) tx_stat_ff <= stat_rdata_i;
      if (st_ff == tester_pkg::ST_R_RX && stat_rvalid_i) begin
        match_ff <= (stat_rdata_i == tx_stat_ff);
      end
    end
  end

  assign stat_araddr_o = araddr_ff;
  assign stat_arvalid_o = ar_phase;
  assign stat_rready_o = r_phase;

  // ==========================================================
  // Indicators
  assign tx_transceiver_lock_indicator_o = tester_pkg::SIMPLEX_TX_BUILD & tx_lock;
  assign rx_transceiver_lock_indicator_o = rx_lock;
  assign rx_alignment_indicator_o = aligned;
  assign gen_busy_indicator_o = gen_busy;
  assign mon_busy_indicator_o = mon_busy;
  assign gen_complete_indicator_o = (gen_ff == tester_pkg::RUN_DONE);
  assign mon_complete_indicator_o = (mon_ff == tester_pkg::RUN_DONE);
  assign mon_mismatch_indicator_o = mismatch_ff;
  assign lane_mode_indicator_o = lane_mode_ff;
  assign stats_match_indicator_o = match_ff;

  // ==========================================================
  // Wishbone register file
  logic ack_ff; // Single-cycle acknowledge
  logic [31:0] rdata_ff; // Registered read data

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr_target = wb_req & wb_we_i & (wb_adr_i == tester_pkg::REG_PKT_TARGET);
  wire [31:0] status_word = {21'h00_0000, cfg_busy, match_ff, lane_mode_ff,
                             tx_lock, rx_lock, aligned, mismatch_ff,
                             mon_complete_indicator_o, gen_complete_indicator_o,
                             mon_busy, gen_busy};
  // Read selection, unmapped offsets read zero
  wire [31:0] rd_mux = (wb_adr_i == tester_pkg::REG_PKT_TARGET) ? {16'h0000, target_ff} :
                       (wb_adr_i == tester_pkg::REG_STATUS) ? status_word :
                       (wb_adr_i == tester_pkg::REG_TX_PKTS) ? {16'h0000, gen_pkt_ff} :
                       (wb_adr_i == tester_pkg::REG_RX_PKTS) ? {16'h0000, mon_pkt_ff} :
                       32'h0000_0000;

  // Acknowledge, read capture and packet target write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      target_ff <= tester_pkg::PKT_TARGET_RST;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) rdata_ff <= rd_mux;
      if (wr_target && wb_sel_i[0]) target_ff[7:0] <= wb_dat_i[7:0];
      if (wr_target && wb_sel_i[1]) target_ff[15:8] <= wb_dat_i[15:8];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule

// ### input_sync.sv
`timescale 1ns/1ps
module input_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);

  // ==========================================================
  // Two-stage synchroniser plus edge history
  logic [W-1:0] meta_ff; // First stage, read only by second
  logic [W-1:0] sync_ff; // Safe level
  logic [W-1:0] hist_ff; // Previous safe level

  // Shift pins through the stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      hist_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o = sync_ff & ~hist_ff; // One pulse per rising edge

endmodule

// ### reconfig_writer.sv
`timescale 1ns/1ps
module reconfig_writer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic target_caui4_i,
  output logic cfg_en_o,
  output logic cfg_we_o,
  output logic [9:0] cfg_addr_o,
  output logic [15:0] cfg_wdata_o,
  input wire logic cfg_rdy_i,
  output logic busy_o,
  output logic done_o
);

  // ==========================================================
  // Sequencer state
  tester_pkg::cfg_state_t state_ff; // Current step
  tester_pkg::cfg_state_t nxt_state;
  logic [tester_pkg::CFG_IDX_W-1:0] idx_ff; // Write index
  logic [9:0] addr_ff; // Address held for the port
  logic [15:0] data_ff; // Data held for the port
  logic done_ff; // Completion pulse

  wire issue = (state_ff == tester_pkg::CFG_ISSUE);
  wire last = (idx_ff == tester_pkg::CFG_LAST);
  // Index of the write shown next, so address and data arrive with the strobe
  wire [tester_pkg::CFG_IDX_W-1:0] nxt_idx = (state_ff == tester_pkg::CFG_IDLE) ? '0
    : idx_ff + 2'(state_ff == tester_pkg::CFG_WAIT && cfg_rdy_i);

  // Next step of the write sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tester_pkg::CFG_IDLE: if (start_i) nxt_state = tester_pkg::CFG_ISSUE;
      tester_pkg::CFG_ISSUE: nxt_state = tester_pkg::CFG_WAIT;
      tester_pkg::CFG_WAIT: begin
        if (cfg_rdy_i) begin
          nxt_state = last ? tester_pkg::CFG_FINISH : tester_pkg::CFG_ISSUE;
        end
      end
      tester_pkg::CFG_FINISH: nxt_state = tester_pkg::CFG_IDLE;
      default: nxt_state = tester_pkg::CFG_IDLE;
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= tester_pkg::CFG_IDLE;
      idx_ff <= '0;
      addr_ff <= '0;
      data_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= (state_ff == tester_pkg::CFG_FINISH);
      idx_ff <= nxt_idx;
      // Table value for the selected lane mode
      addr_ff <= tester_pkg::CFG_ADDR[nxt_idx];
      data_ff <= target_caui4_i ? tester_pkg::CFG_DATA_CAUI4[nxt_idx]
                                : tester_pkg::CFG_DATA_CAUI10[nxt_idx];
    end
  end

  assign cfg_en_o = issue;
  assign cfg_we_o = issue;
  assign cfg_addr_o = addr_ff;
  assign cfg_wdata_o = data_ff;
  assign busy_o = (state_ff != tester_pkg::CFG_IDLE) | done_ff;
  assign done_o = done_ff;

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
// ======
// Bench for the traffic tester
module tb_top;
  logic clk_i, rst_i, continuous_traffic_select_i, lane_mode_change_pulse_i;
  logic test_restart_request_i, perf_snapshot_pulse_i, rx_transceiver_locked_i;
  logic tx_transceiver_locked_i, rx_aligned_i, remote_receiver_aligned_i, tx_valid_o;
  logic tx_ready_i, tx_sop_o, tx_eop_o, rx_valid_i, rx_sop_i, rx_eop_i, cfg_en_o, cfg_we_o;
  logic cfg_rdy_i, reconfig_write_complete_o, stat_arvalid_o, stat_arready_i, stat_rvalid_i;
  logic stat_rready_o, tx_transceiver_lock_indicator_o, rx_transceiver_lock_indicator_o;
  logic rx_alignment_indicator_o, gen_busy_indicator_o, mon_busy_indicator_o;
  logic gen_complete_indicator_o, mon_complete_indicator_o, mon_mismatch_indicator_o;
  logic lane_mode_indicator_o, stats_match_indicator_o, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic [31:0] tx_data_o, rx_data_i, stat_araddr_o, stat_rdata_i, wb_dat_i, wb_dat_o, rd;
  logic [9:0] cfg_addr_o;
  logic [15:0] cfg_wdata_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [2:0] btn; // Lane, restart, snapshot buttons
  logic stall_en, stall, corrupt, bad_stats; // Far-end controls
  logic [25:0] cfg_log [8]; // Config writes seen
  int seed, n_fail, num_checks, cycles, n_cfg, base;
  assign {perf_snapshot_pulse_i, test_restart_request_i, lane_mode_change_pulse_i} = btn;

  eth_traffic_sanity_tester DUT (.*);
  core_model far_end (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .corrupt_i(corrupt),
    .bad_stats_i(bad_stats), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .tx_sop_i(tx_sop_o), .tx_eop_i(tx_eop_o), .tx_ready_o(tx_ready_i),
    .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_sop_o(rx_sop_i), .rx_eop_o(rx_eop_i),
    .cfg_en_i(cfg_en_o), .cfg_rdy_o(cfg_rdy_i), .stat_arvalid_i(stat_arvalid_o),
    .stat_araddr_i(stat_araddr_o), .stat_arready_o(stat_arready_i),
    .stat_rvalid_o(stat_rvalid_i), .stat_rdata_o(stat_rdata_i), .stat_rready_i(stat_rready_o));

  // ======
  // Clock, stall, config log, timeout
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    stall <= stall_en && (($random(seed) & 3) == 0);
    if (cfg_en_o === 1'b1) begin
      cfg_log[3'(n_cfg)] <= {cfg_addr_o, cfg_wdata_o};
      n_cfg <= n_cfg + 1;
    end
    if (cycles == 40000) begin
      n_fail++;
      test_done();
    end
  end

  // ======
  // Tasks and expectations
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Single Wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic press(input int b);
    @(posedge clk_i) btn[b] <= 1'b1;
    repeat (4) @(posedge clk_i);
    btn[b] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wait_done;
    while ((gen_complete_indicator_o & mon_complete_indicator_o) !== 1'b1)
      @(posedge clk_i);
  endtask
  function automatic logic [31:0] exp_status(input logic mis, lane, match);
    return {22'h0, match, lane, 3'b111, mis, 4'b1100};
  endfunction
  function automatic logic [25:0] exp_cfg(input int i, input logic caui4);
    return {tester_pkg::CFG_ADDR[i],
      caui4 ? tester_pkg::CFG_DATA_CAUI4[i] : tester_pkg::CFG_DATA_CAUI10[i]};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ======
  // Main sequence
  initial begin
    seed = 21;
    {n_fail, num_checks, cycles, n_cfg} = '0;
    {rst_i, rx_transceiver_locked_i, tx_transceiver_locked_i, rx_aligned_i} = 4'hF;
    {continuous_traffic_select_i, btn, corrupt, bad_stats, stall, stall_en} = 8'h01;
    remote_receiver_aligned_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_done; // Fixed run after reset
    wb(1'b0, tester_pkg::REG_TX_PKTS, 32'h0);
    chk("tx packets", rd, 32'h0000_0040);
    wb(1'b0, tester_pkg::REG_RX_PKTS, 32'h0);
    chk("rx packets", rd, 32'h0000_0040);
    wb(1'b1, tester_pkg::REG_STATUS, 32'h0000_0000);
    wb(1'b0, tester_pkg::REG_STATUS, 32'h0);
    chk("status", rd, exp_status(1'b0, 1'b0, 1'b1));
    chk("lamps", {tx_transceiver_lock_indicator_o, rx_transceiver_lock_indicator_o},
      {tester_pkg::SIMPLEX_TX_BUILD, 1'b1});
    wb(1'b0, 8'h10, 32'h0000_1234);
    chk("unmapped", rd, 32'h0000_0000);
    // Short random run, corrupted beat, busy restart
    wb(1'b1, tester_pkg::REG_PKT_TARGET, 32'h0000_0008 + ($random(seed) & 32'hF));
    base = int'(wb_dat_i);
    press(1);
    chk("restart busy", mon_busy_indicator_o, 1'b1);
    while ((tx_valid_o & tx_ready_i) !== 1'b1) @(posedge clk_i);
    corrupt <= 1'b1;
    repeat (4) @(posedge clk_i);
    corrupt <= 1'b0;
    press(1);
    wait_done;
    chk("mismatch kept", mon_mismatch_indicator_o, 1'b1);
    wb(1'b0, tester_pkg::REG_TX_PKTS, 32'h0);
    chk("fixed count", rd, 32'(base));
    // No traffic without alignment
    rx_aligned_i <= 1'b0;
    press(1);
    chk("aligned lamp", rx_alignment_indicator_o, 1'b0);
    chk("mismatch cleared", mon_mismatch_indicator_o, 1'b0);
    repeat (40) @(posedge clk_i) chk("gated tx", tx_valid_o, 1'b0);
    rx_aligned_i <= 1'b1;
    wait_done;
    // Continuous run, then lane change each way
    for (int m = 0; m < 2; m++) begin
      continuous_traffic_select_i <= 1'b1;
      press(1);
      repeat (1200) @(posedge clk_i);
      chk("endless run", gen_complete_indicator_o, 1'b0);
      continuous_traffic_select_i <= 1'b0;
      stall_en <= 1'b0;
      base = n_cfg;
      press(0);
      while (lane_mode_indicator_o !== !m[0]) @(posedge clk_i);
      stall_en <= 1'b1;
      chk("cfg writes", 32'(n_cfg - base), 32'h4);
      for (int i = 0; i < 4; i++) chk("cfg", 32'(cfg_log[3'(base + i)]), 32'(exp_cfg(i, !m[0])));
      wait_done;
      chk("rerun clean", mon_mismatch_indicator_o, 1'b0);
    end
    // Stats compare, bad then good
    for (int s = 1; s >= 0; s--) begin
      bad_stats <= s[0];
      press(2);
      repeat (20) @(posedge clk_i);
      chk("stats match", stats_match_indicator_o, !s[0]);
    end
    test_done;
  end
endmodule

// ### tester_monitor.sv
`timescale 1ns/1ps
// ======
// Traffic tester checker
module tester_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [31:0] tx_data_o,
  input wire logic tx_sop_o,
  input wire logic tx_eop_o,
  input wire logic cfg_en_o,
  input wire logic cfg_we_o,
  input wire logic reconfig_write_complete_o,
  input wire logic lane_mode_indicator_o,
  input wire logic stat_arvalid_o,
  input wire logic stat_arready_i,
  input wire logic [31:0] stat_araddr_o,
  input wire logic stat_rready_o,
  input wire logic gen_busy_indicator_o,
  input wire logic gen_complete_indicator_o,
  input wire logic mon_busy_indicator_o,
  input wire logic mon_complete_indicator_o
);
  // One clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ======
  // Bus, stream, config port, lane mode, run state and stats reads
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("stalled beat changed");
  a_beat_frame: assert property (tx_valid_o |-> tx_data_o[15:8] == tester_pkg::PAD_BYTE
    && tx_sop_o == (tx_data_o[7:0] == 8'h00)
    && tx_eop_o == (tx_data_o[7:0] == tester_pkg::PKT_LAST_BEAT))
    else $error("beat framing wrong");
  a_cfg_pulse: assert property (cfg_en_o |-> cfg_we_o ##1 !cfg_en_o)
    else $error("config write too long");
  a_lane_flip: assert property (reconfig_write_complete_o |=>
    lane_mode_indicator_o != $past(lane_mode_indicator_o) && !reconfig_write_complete_o)
    else $error("lane mode not toggled");
  a_gen_state: assert property (gen_busy_indicator_o |-> !gen_complete_indicator_o)
    else $error("gen busy and done");
  a_mon_state: assert property (mon_busy_indicator_o |-> !mon_complete_indicator_o)
    else $error("mon busy and done");
  a_stat_hold: assert property (stat_arvalid_o && !stat_arready_i |=>
    stat_arvalid_o && $stable(stat_araddr_o))
    else $error("stats request dropped");
  a_stat_order: assert property (stat_arvalid_o && stat_arready_i |=>
    stat_rready_o && !stat_arvalid_o)
    else $error("stats data phase missing");
  // Scenarios reached
  c_lane: cover property (reconfig_write_complete_o);
  c_done: cover property ($rose(gen_complete_indicator_o));
  c_stat: cover property (stat_arvalid_o && stat_arready_i);
endmodule

bind eth_traffic_sanity_tester tester_monitor mon (.*);

// ### tester_pkg.sv
package tester_pkg;

  // ==========================================================
  // Widths and stream pattern
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int BEAT_W = 8;
  localparam logic [BEAT_W-1:0] PKT_LAST_BEAT = 8'h07;
  localparam logic [CNT_W-1:0] PKT_TARGET_RST = 16'h0040;
  localparam logic [7:0] PAD_BYTE = 8'hA5;

  // ==========================================================
  // Build options and reset values
  localparam logic SIMPLEX_TX_BUILD = 1'b0;
  localparam logic RUNTIME_SWITCH_BUILD = 1'b1;
  localparam logic STATS_BUILD = 1'b1;
  localparam logic LANE_MODE_RST = 1'b0;
  localparam logic STATS_MATCH_RST = 1'b1;

  // ==========================================================
  // Positions in the synchronised pin vector
  localparam int PIN_CONT = 0;
  localparam int PIN_LANE = 1;
  localparam int PIN_RESTART = 2;
  localparam int PIN_SNAP = 3;
  localparam int PIN_RX_LOCK = 4;
  localparam int PIN_TX_LOCK = 5;
  localparam int PIN_ALIGN = 6;
  localparam int PIN_REMOTE = 7;
  localparam int PIN_W = 8;

  // ==========================================================
  // Wishbone register offsets
  localparam logic [7:0] REG_PKT_TARGET = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TX_PKTS = 8'h08;
  localparam logic [7:0] REG_RX_PKTS = 8'h0C;

  // ==========================================================
  // Transceiver configuration write sequence
  localparam int CFG_WRITES = 4;
  localparam int CFG_IDX_W = 2;
  localparam logic [CFG_IDX_W-1:0] CFG_LAST = 2'h3;
  localparam logic [9:0] CFG_ADDR [CFG_WRITES] = '{10'h010, 10'h020, 10'h030, 10'h040};
  localparam logic [15:0] CFG_DATA_CAUI4 [CFG_WRITES] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004};
  localparam logic [15:0] CFG_DATA_CAUI10 [CFG_WRITES] = '{16'h0010, 16'h0020, 16'h0030, 16'h0040};

  // ==========================================================
  // Statistics read addresses
  localparam logic [31:0] STAT_TX_ADDR = 32'h0000_0500;
  localparam logic [31:0] STAT_RX_ADDR = 32'h0000_0600;

  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_WAIT = 2'b01,
    RUN_ACTIVE = 2'b10,
    RUN_DONE = 2'b11
  } run_state_t;

  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_ISSUE = 2'b01,
    CFG_WAIT = 2'b10,
    CFG_FINISH = 2'b11
  } cfg_state_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_AR_TX = 3'b001,
    ST_R_TX = 3'b010,
    ST_AR_RX = 3'b011,
    ST_R_RX = 3'b100
  } stat_state_t;

endpackage
